// [logic/cpu_status.sv]
// Processor status word, stack selection and register bank pointer
//
// Decided for this implementation: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/1ps
module cpu_status
  import cpu_status_pkg::*;
(
  input  wire logic        mclk,            // Core clock, 25 MHz
  input  wire logic        rst_n,           // Synchronous reset, active low
  input  wire logic [7:0]  avs_address,     // Avalon byte address
  input  wire logic        avs_read,        // Avalon read
  input  wire logic        avs_write,       // Avalon write
  input  wire logic [31:0] avs_writedata,   // Avalon write data
  input  wire logic [3:0]  avs_byteenable,  // Avalon byte enables
  output logic      [31:0] avs_readdata,    // Avalon read data
  output logic             avs_waitrequest, // Avalon wait request
  input  wire logic        alu_valid,       // Update flags from this operation
  input  wire logic [2:0]  alu_op,          // Operation code
  input  wire logic [15:0] alu_a,           // First operand
  input  wire logic [15:0] alu_b,           // Second operand
  input  wire logic [3:0]  alu_shamt,       // Right shift count
  output logic      [15:0] alu_result,      // Registered result
  input  wire logic        irq_req,         // Hardware interrupt request
  input  wire logic [2:0]  irq_level,       // Resource level bits of requester
  input  wire logic        swi_req,         // Software interrupt taken
  output logic             irq_ack,         // Hardware interrupt accepted pulse
  input  wire logic        rp_load,         // Immediate load of bank pointer
  input  wire logic [7:0]  rp_imm,          // Immediate value
  input  wire logic        stk_req,         // Word stack access request
  input  wire logic        stk_push,        // 1 push, 0 pop
  output logic             stk_ready,       // Ready for a stack request
  output logic             stk_strobe,      // One memory access this cycle
  output logic             stk_byte,        // Access is a byte access
  output logic             stk_wr,          // Access is a write
  output logic      [23:0] stk_addr,        // Stack memory address
  output logic      [15:0] status_word,     // Current status word
  output logic      [23:0] gpr_base         // Current register bank start
);

  logic [2:0]  ilm_reg;
  logic [4:0]  rp_reg;
  logic        ie_reg;
  logic        ss_reg;
  logic [4:0]  flags_reg;
  logic [15:0] usp_reg;
  logic [15:0] ssp_reg;
  logic [7:0]  usb_reg;
  logic [7:0]  ssb_reg;
  logic [31:0] rdata_reg;
  logic        wait_reg;
  logic        ack_reg;
  logic [15:0] res_reg;
  logic        ready_reg;
  logic        strobe_reg;
  logic        byte_reg;
  logic        wr_reg;
  logic [23:0] addr_reg;
  logic [15:0] sw_reg;
  logic [23:0] base_reg;
  stk_state_e  st_reg;

  logic [15:0] res_next;
  logic        f_t;
  logic        f_n;
  logic        f_z;
  logic        f_v;
  logic        f_c;
  logic        upd_t;
  logic        upd_c;
  logic        bus_req;
  logic        wr_ok;
  logic        irq_take;
  logic [15:0] sp_sel;
  logic [7:0]  sb_sel;
  logic [15:0] sp_next;
  logic [15:0] acc_ptr;
  logic        stk_go;
  logic [15:0] status_next;

  flag_unit u_flags (
    .op    (alu_op),
    .op_a  (alu_a),
    .op_b  (alu_b),
    .shamt (alu_shamt),
    .res   (res_next),
    .f_t   (f_t),
    .f_n   (f_n),
    .f_z   (f_z),
    .f_v   (f_v),
    .f_c   (f_c),
    .upd_t (upd_t),
    .upd_c (upd_c)
  );

  assign bus_req  = avs_read || avs_write;
  assign wr_ok    = avs_write && !wait_reg;
  // Lower level value means higher priority; mask 0 blocks everything
  assign irq_take = irq_req && ie_reg && (irq_level < ilm_reg);
  assign sp_sel   = ss_reg ? ssp_reg : usp_reg;
  assign sb_sel   = ss_reg ? ssb_reg : usb_reg;
  assign sp_next  = stk_push ? 16'(sp_sel - SP_STEP) : 16'(sp_sel + SP_STEP);
  assign acc_ptr  = stk_push ? sp_next : sp_sel;
  assign stk_go   = stk_req && (st_reg == ST_IDLE);
  assign status_next = {ilm_reg, rp_reg, 1'b0, ie_reg, ss_reg, flags_reg};

  // Bus handshake: one wait cycle, then the access completes
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      wait_reg <= 1'b1;
    end else begin
      wait_reg <= !(bus_req && wait_reg);
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      rdata_reg <= 32'h00000000;
    end else if (avs_read && wait_reg) begin
      case (avs_address)
        OFS_STATUS:   rdata_reg <= {16'h0000, status_next};
        OFS_USP:      rdata_reg <= {16'h0000, usp_reg};
        OFS_SSP:      rdata_reg <= {16'h0000, ssp_reg};
        OFS_USB:      rdata_reg <= {24'h000000, usb_reg};
        OFS_SSB:      rdata_reg <= {24'h000000, ssb_reg};
        OFS_RBP:      rdata_reg <= {27'h0000000, rp_reg};
        OFS_GPR_BASE: rdata_reg <= {8'h00, gpr_start(rp_reg)};
        OFS_STK_ADDR: rdata_reg <= {8'h00, stack_address(sb_sel, sp_sel)};
        default:      rdata_reg <= 32'h00000000;
      endcase
    end
  end

  // Interrupt mask, enable and stack select; interrupt acceptance wins
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      ilm_reg <= RST_ILM;
      ie_reg  <= RST_IE;
      ss_reg  <= RST_SS;
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= irq_take;
      if (wr_ok && avs_address == OFS_STATUS && avs_byteenable[1]) begin
        ilm_reg <= avs_writedata[ILM_LSB +: 3];
      end
      if (wr_ok && avs_address == OFS_STATUS && avs_byteenable[0]) begin
        ie_reg <= avs_writedata[IE_BIT];
        ss_reg <= avs_writedata[SS_BIT];
      end
      if (irq_take) begin
        ilm_reg <= irq_level;
        ss_reg  <= 1'b1;
      end else if (swi_req) begin
        ss_reg  <= 1'b1;
      end
    end
  end

  // Bank pointer; only the low five bits of an immediate are kept
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      rp_reg <= RST_RP;
    end else if (rp_load) begin
      rp_reg <= rp_imm[4:0];
    end else if (wr_ok && avs_byteenable[1] && avs_address == OFS_STATUS) begin
      rp_reg <= avs_writedata[RP_LSB +: 5];
    end else if (wr_ok && avs_byteenable[0] && avs_address == OFS_RBP) begin
      rp_reg <= avs_writedata[4:0];
    end
  end

  // Condition flags; an operation in the same cycle beats a bus write
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      flags_reg <= RST_FLAGS;
      res_reg   <= 16'h0000;
    end else if (alu_valid) begin
      res_reg          <= res_next;
      flags_reg[N_BIT] <= f_n;
      flags_reg[Z_BIT] <= f_z;
      flags_reg[V_BIT] <= f_v;
      if (upd_c) begin
        flags_reg[C_BIT] <= f_c;
      end
      if (upd_t) begin
        flags_reg[T_BIT] <= f_t;
      end
    end else if (wr_ok && avs_address == OFS_STATUS && avs_byteenable[0]) begin
      flags_reg <= avs_writedata[4:0];
    end
  end

  // Stack pointers keep no reset value; software must load them
  always_ff @(posedge mclk) begin
    if (stk_go && ss_reg) begin
      ssp_reg <= sp_next;
    end else if (wr_ok && avs_address == OFS_SSP) begin
      if (avs_byteenable[0]) ssp_reg[7:0] <= avs_writedata[7:0];
      if (avs_byteenable[1]) ssp_reg[15:8] <= avs_writedata[15:8];
    end
    if (stk_go && !ss_reg) begin
      usp_reg <= sp_next;
    end else if (wr_ok && avs_address == OFS_USP) begin
      if (avs_byteenable[0]) usp_reg[7:0] <= avs_writedata[7:0];
      if (avs_byteenable[1]) usp_reg[15:8] <= avs_writedata[15:8];
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      usb_reg <= 8'h00;
      ssb_reg <= 8'h00;
    end else if (wr_ok && avs_byteenable[0]) begin
      if (avs_address == OFS_USB) usb_reg <= avs_writedata[7:0];
      if (avs_address == OFS_SSB) ssb_reg <= avs_writedata[7:0];
    end
  end

  // Stack access sequencer; an odd pointer costs a second byte access
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      st_reg     <= ST_IDLE;
      ready_reg  <= 1'b1;
      strobe_reg <= 1'b0;
      byte_reg   <= 1'b0;
      wr_reg     <= 1'b0;
      addr_reg   <= 24'h000000;
    end else begin
      case (st_reg)
        ST_IDLE: begin
          strobe_reg <= stk_go;
          if (stk_go) begin
            addr_reg  <= stack_address(sb_sel, acc_ptr);
            wr_reg    <= stk_push;
            byte_reg  <= acc_ptr[0];
            ready_reg <= !acc_ptr[0];
            if (acc_ptr[0]) begin
              st_reg <= ST_SPLIT;
            end
          end
        end
        ST_SPLIT: begin
          strobe_reg <= 1'b1;
          byte_reg   <= 1'b1;
          addr_reg   <= {addr_reg[23:16], 16'(addr_reg[15:0] + 16'h0001)};
          ready_reg  <= 1'b1;
          st_reg     <= ST_IDLE;
        end
        default: begin
          st_reg     <= ST_IDLE;
          strobe_reg <= 1'b0;
          ready_reg  <= 1'b1;
        end
      endcase
    end
  end

  // Registered views for the rest of the core
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      sw_reg   <= {RST_ILM, RST_RP, 1'b0, RST_IE, RST_SS, RST_FLAGS};
      base_reg <= GPR_BASE;
    end else begin
      sw_reg   <= status_next;
      base_reg <= gpr_start(rp_reg);
    end
  end

  assign avs_readdata    = rdata_reg;
  assign avs_waitrequest = wait_reg;
  assign alu_result      = res_reg;
  assign irq_ack         = ack_reg;
  assign stk_ready       = ready_reg;
  assign stk_strobe      = strobe_reg;
  assign stk_byte        = byte_reg;
  assign stk_wr          = wr_reg;
  assign stk_addr        = addr_reg;
  assign status_word     = sw_reg;
  assign gpr_base        = base_reg;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  sequence s_odd_start;
    stk_go && acc_ptr[0];
  endsequence

  sequence s_two_bytes;
    (stk_strobe && stk_byte && !stk_ready) ##1 (stk_strobe && stk_byte && stk_ready);
  endsequence

  a_reset_state:
    assert property ($rose(rst_n) |-> ss_reg && !ie_reg && ilm_reg == 3'h0 && rp_reg == 5'h00)
    else $error("reset values of status fields wrong");

  a_irq_forces_sys:
    assert property (irq_take |=> irq_ack && ss_reg && ilm_reg == $past(irq_level))
    else $error("accepted interrupt did not select system stack");

  a_irq_blocked:
    assert property (irq_req && (!ie_reg || irq_level >= ilm_reg) |=> !irq_ack)
    else $error("interrupt accepted while blocked");

  a_rp_imm_low:
    assert property (rp_load |=> rp_reg == $past(rp_imm[4:0]))
    else $error("bank pointer immediate load wrong");

  a_gpr_base_calc:
    assert property (##1 gpr_base == 24'h000180 + {15'h0000, $past(rp_reg), 4'h0})
    else $error("bank start address wrong");

  a_stack_bank_sel:
    assert property (stk_go |=> stk_strobe && stk_addr[23:16] == $past(ss_reg ? ssb_reg : usb_reg))
    else $error("stack bank selection wrong");

  a_odd_split_two:
    assert property (s_odd_start |=> s_two_bytes)
    else $error("odd pointer not split into two byte accesses");

  a_even_single:
    assert property (stk_go && !acc_ptr[0] |=> stk_strobe && !stk_byte
                     ##1 (!stk_strobe || $past(stk_go)))
    else $error("even pointer access not a single word");

  a_zero_neg_flag:
    assert property (alu_valid |=> flags_reg[Z_BIT] == (alu_result == 16'h0000)
                     && flags_reg[N_BIT] == alu_result[15])
    else $error("zero or negative flag disagrees with result");

  a_sticky_no_shift:
    assert property (alu_valid && (alu_op == OP_LSR || alu_op == OP_ASR) && alu_shamt == 4'h0
                     |=> !flags_reg[T_BIT])
    else $error("sticky set with zero shift count");

endmodule : cpu_status

// [logic/flag_unit.sv]
// Combinational result and condition flag computation
`timescale 1ns/1ps
module flag_unit
  import cpu_status_pkg::*;
(
  input  wire logic [2:0]  op,     // Operation code
  input  wire logic [15:0] op_a,   // First operand
  input  wire logic [15:0] op_b,   // Second operand
  input  wire logic [3:0]  shamt,  // Right shift count
  output logic      [15:0] res,    // Operation result
  output logic             f_t,    // Sticky
  output logic             f_n,    // Negative
  output logic             f_z,    // Zero
  output logic             f_v,    // Signed overflow
  output logic             f_c,    // Carry or borrow
  output logic             upd_t,  // Sticky is affected
  output logic             upd_c   // Carry is affected
);

  logic [16:0] wide;
  logic [15:0] lost_mask;
  logic [3:0]  sh_m1;

  always_comb begin
    wide      = 17'h00000;
    sh_m1     = 4'(shamt - 4'h1);
    lost_mask = 16'((16'h0001 << sh_m1) - 16'h0001);
    res       = 16'h0000;
    f_v       = 1'b0;
    f_c       = 1'b0;
    f_t       = 1'b0;
    upd_t     = 1'b0;
    upd_c     = 1'b1;
    case (op)
      OP_ADD: begin
        wide = {1'b0, op_a} + {1'b0, op_b};
        res  = wide[15:0];
        f_c  = wide[16];
        f_v  = (op_a[15] == op_b[15]) && (res[15] != op_a[15]);
      end
      OP_SUB: begin
        wide = {1'b0, op_a} - {1'b0, op_b};
        res  = wide[15:0];
        f_c  = wide[16];
        f_v  = (op_a[15] != op_b[15]) && (res[15] != op_a[15]);
      end
      OP_AND: begin
        res   = op_a & op_b;
        upd_c = 1'b0;
      end
      OP_OR: begin
        res   = op_a | op_b;
        upd_c = 1'b0;
      end
      OP_XOR: begin
        res   = op_a ^ op_b;
        upd_c = 1'b0;
      end
      OP_LSR, OP_ASR: begin
        if (op == OP_LSR) begin
          res = op_a >> shamt;
        end else begin
          res = 16'($signed(op_a) >>> shamt);
        end
        upd_t = 1'b1;
        // Bits that passed through carry and were lost set sticky
        if (shamt != 4'h0) begin
          f_c = op_a[sh_m1];
          f_t = |(op_a & lost_mask);
        end
      end
      default: begin
        res   = op_a;
        upd_c = 1'b0;
      end
    endcase
    f_n = res[15];
    f_z = (res == 16'h0000);
  end

endmodule : flag_unit

// [pkg/cpu_status_pkg.sv]
// Shared constants and helpers for the processor status and stack select block
package cpu_status_pkg;

  // Register byte offsets on the Avalon-MM slave
  localparam logic [7:0] OFS_STATUS   = 8'h00;
  localparam logic [7:0] OFS_USP      = 8'h04;
  localparam logic [7:0] OFS_SSP      = 8'h08;
  localparam logic [7:0] OFS_USB      = 8'h0c;
  localparam logic [7:0] OFS_SSB      = 8'h10;
  localparam logic [7:0] OFS_RBP      = 8'h14;
  localparam logic [7:0] OFS_GPR_BASE = 8'h18;
  localparam logic [7:0] OFS_STK_ADDR = 8'h1c;

  // Status word field positions
  localparam int ILM_LSB = 13;
  localparam int RP_LSB  = 8;
  localparam int IE_BIT  = 6;
  localparam int SS_BIT  = 5;
  localparam int T_BIT   = 4;
  localparam int N_BIT   = 3;
  localparam int Z_BIT   = 2;
  localparam int V_BIT   = 1;
  localparam int C_BIT   = 0;

  // Reset values
  localparam logic [2:0] RST_ILM   = 3'h0;
  localparam logic [4:0] RST_RP    = 5'h00;
  localparam logic       RST_IE    = 1'b0;
  localparam logic       RST_SS    = 1'b1;
  localparam logic [4:0] RST_FLAGS = 5'h00;

  // Register bank area and stack step
  localparam logic [23:0] GPR_BASE = 24'h000180;
  localparam logic [15:0] SP_STEP  = 16'h0002;

  // Flag unit operation codes
  localparam logic [2:0] OP_ADD = 3'h0;
  localparam logic [2:0] OP_SUB = 3'h1;
  localparam logic [2:0] OP_AND = 3'h2;
  localparam logic [2:0] OP_OR  = 3'h3;
  localparam logic [2:0] OP_XOR = 3'h4;
  localparam logic [2:0] OP_LSR = 3'h5;
  localparam logic [2:0] OP_ASR = 3'h6;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b01,
    ST_SPLIT = 2'b10
  } stk_state_e;

  // Bank start address: base plus pointer times 0x10
  function automatic logic [23:0] gpr_start(input logic [4:0] rp);
    gpr_start = GPR_BASE + {15'h0000, rp, 4'h0};
  endfunction : gpr_start

  // 24-bit stack address from bank and pointer
  function automatic logic [23:0] stack_address(input logic [7:0] bank,
                                                input logic [15:0] ptr);
    stack_address = {bank, ptr};
  endfunction : stack_address

endpackage : cpu_status_pkg

// [test/cpu_status_and_stack_select_tb.sv]
// Self-checking bench for the status word, stack select and bank pointer block
`timescale 1ns/1ps
module cpu_status_and_stack_select_tb
  import cpu_status_pkg::*;
;
  logic        mclk;
  logic        rst_n;
  logic [7:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [3:0]  avs_byteenable;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        alu_valid;
  logic [2:0]  alu_op;
  logic [15:0] alu_a;
  logic [15:0] alu_b;
  logic [3:0]  alu_shamt;
  logic [15:0] alu_result;
  logic        irq_req;
  logic [2:0]  irq_level;
  logic        swi_req;
  logic        irq_ack;
  logic        rp_load;
  logic [7:0]  rp_imm;
  logic        stk_req;
  logic        stk_push;
  logic        stk_ready;
  logic        stk_strobe;
  logic        stk_byte;
  logic        stk_wr;
  logic [23:0] stk_addr;
  logic [15:0] status_word;
  logic [23:0] gpr_base;
  int          miscompares;
  int          total_checks;

  cpu_status dut (
    .mclk(mclk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .alu_valid(alu_valid),
    .alu_op(alu_op), .alu_a(alu_a), .alu_b(alu_b), .alu_shamt(alu_shamt),
    .alu_result(alu_result), .irq_req(irq_req), .irq_level(irq_level), .swi_req(swi_req),
    .irq_ack(irq_ack), .rp_load(rp_load), .rp_imm(rp_imm), .stk_req(stk_req),
    .stk_push(stk_push), .stk_ready(stk_ready), .stk_strobe(stk_strobe),
    .stk_byte(stk_byte), .stk_wr(stk_wr), .stk_addr(stk_addr),
    .status_word(status_word), .gpr_base(gpr_base)
  );

  always #20 mclk = ~mclk;

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      $display("[ERR] %s expected %h seen %h", name, exp, got);
      miscompares++;
    end
  endtask : chk

  task automatic end_sim();
    if (miscompares == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : end_sim

  // Request held until waitrequest is sampled low; data taken at that same edge
  task automatic bus_xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                          output logic [31:0] q);
    int n;
    @(posedge mclk);
    avs_read      <= !wr;
    avs_write     <= wr;
    avs_address   <= a;
    avs_writedata <= d;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (avs_waitrequest !== 1'h0 && n < 20);
    q = avs_readdata;
    avs_read  <= 1'h0;
    avs_write <= 1'h0;
    chk("waitrequest", 32'h0, avs_waitrequest);
    if (avs_waitrequest !== 1'h0) end_sim();
  endtask : bus_xfer

  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus_xfer(1'h1, a, d, q);
  endtask : bus_wr

  task automatic bus_rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus_xfer(1'h0, a, 32'h0, q);
    chk($sformatf("readdata at %h", a), exp, q);
  endtask : bus_rd

  task automatic alu_chk(input logic [2:0] op, input logic [15:0] a, input logic [15:0] b,
                         input logic [3:0] sh, input logic [15:0] r, input logic [4:0] f);
    @(posedge mclk);
    alu_valid <= 1'h1;
    alu_op    <= op;
    alu_a     <= a;
    alu_b     <= b;
    alu_shamt <= sh;
    @(posedge mclk);
    alu_valid <= 1'h0;
    @(posedge mclk);
    #1;
    chk("alu_result", r, alu_result);
    chk("flags TNZVC", f, status_word[4:0]);
  endtask : alu_chk

  task automatic rp_try(input logic [7:0] imm, input logic [4:0] p);
    @(posedge mclk);
    rp_load <= 1'h1;
    rp_imm  <= imm;
    @(posedge mclk);
    rp_load <= 1'h0;
    // Bank start trails the pointer by one cycle
    @(posedge mclk);
    #1;
    chk("bank pointer", p, status_word[12:8]);
    chk("gpr_base", 24'h000180 + {p, 4'h0}, gpr_base);
  endtask : rp_try

  task automatic stk_op(input logic push, input logic [23:0] a0, input logic odd);
    @(posedge mclk);
    stk_req  <= 1'h1;
    stk_push <= push;
    @(posedge mclk);
    stk_req <= 1'h0;
    #1;
    chk("stk_strobe", 32'h1, stk_strobe);
    chk("stk_byte", odd, stk_byte);
    chk("stk_wr", push, stk_wr);
    chk("stk_addr", a0, stk_addr);
    chk("stk_ready", !odd, stk_ready);
    @(posedge mclk);
    #1;
    chk("second stk_strobe", odd, stk_strobe);
    if (odd) chk("second stk_addr", a0 + 24'h1, stk_addr);
  endtask : stk_op

  task automatic irq_try(input logic [2:0] lvl, input logic ack, input logic [15:0] st);
    @(posedge mclk);
    irq_req   <= 1'h1;
    irq_level <= lvl;
    @(posedge mclk);
    irq_req <= 1'h0;
    #1;
    chk("irq_ack", ack, irq_ack);
    // Status word view trails the mask by one cycle
    @(posedge mclk);
    #1;
    chk("irq_ack pulse", 32'h0, irq_ack);
    chk("status_word", st, status_word);
  endtask : irq_try

  initial begin
    mclk = 1'h0; rst_n = 1'h0; avs_address = 8'h0; avs_read = 1'h0; avs_write = 1'h0;
    avs_writedata = 32'h0; avs_byteenable = 4'hf; alu_valid = 1'h0; alu_op = 3'h0;
    alu_a = 16'h0; alu_b = 16'h0; alu_shamt = 4'h0; irq_req = 1'h0; irq_level = 3'h0;
    swi_req = 1'h0; rp_load = 1'h0; rp_imm = 8'h0; stk_req = 1'h0; stk_push = 1'h0;
    miscompares = 0;
    total_checks = 0;
    repeat (5) @(posedge mclk);
    rst_n <= 1'h1;
    @(posedge mclk);
    #1;
    chk("status_word", 32'h0020, status_word);
    chk("gpr_base", 32'h000180, gpr_base);
    bus_rd(OFS_STATUS, 32'h0020);
    bus_rd(OFS_USB, 32'h0);
    bus_rd(OFS_SSB, 32'h0);
    bus_rd(8'h40, 32'h0);
    bus_wr(8'h40, 32'hffffffff);
    bus_wr(OFS_GPR_BASE, 32'h0);
    bus_rd(OFS_GPR_BASE, 32'h000180);
    bus_rd(OFS_STATUS, 32'h0020);
    alu_chk(OP_ADD, 16'h7fff, 16'h0001, 4'h0, 16'h8000, 5'h0a);
    alu_chk(OP_ADD, 16'hffff, 16'h0001, 4'h0, 16'h0000, 5'h05);
    alu_chk(OP_SUB, 16'h0000, 16'h0001, 4'h0, 16'hffff, 5'h09);
    alu_chk(OP_SUB, 16'h8000, 16'h0001, 4'h0, 16'h7fff, 5'h02);
    alu_chk(OP_LSR, 16'h0005, 16'h0000, 4'h2, 16'h0001, 5'h10);
    alu_chk(OP_AND, 16'hf0f0, 16'h0ff0, 4'h0, 16'h00f0, 5'h10);
    alu_chk(OP_LSR, 16'h0006, 16'h0000, 4'h2, 16'h0001, 5'h01);
    alu_chk(OP_XOR, 16'h0f0f, 16'h0f0f, 4'h0, 16'h0000, 5'h05);
    alu_chk(OP_OR, 16'h8000, 16'h0001, 4'h0, 16'h8001, 5'h09);
    alu_chk(OP_ASR, 16'h8001, 16'h0000, 4'h1, 16'hc000, 5'h09);
    alu_chk(OP_ASR, 16'h8000, 16'h0000, 4'h0, 16'h8000, 5'h08);
    // Unused bit 7 and upper half read back as zero
    bus_wr(OFS_STATUS, 32'hffffffff);
    bus_rd(OFS_STATUS, 32'h0000ff7f);
    bus_rd(OFS_GPR_BASE, 32'h000370);
    rp_try(8'he5, 5'h05);
    rp_try(8'h20, 5'h00);
    rp_try(8'h1f, 5'h1f);
    bus_wr(OFS_RBP, 32'h000000ea);
    bus_rd(OFS_GPR_BASE, 32'h000220);
    bus_wr(OFS_SSP, 32'h1000);
    bus_wr(OFS_SSB, 32'h12);
    bus_wr(OFS_USP, 32'h2000);
    bus_wr(OFS_USB, 32'h34);
    bus_rd(OFS_STK_ADDR, 32'h121000);
    bus_wr(OFS_STATUS, 32'ha040);
    bus_rd(OFS_STK_ADDR, 32'h342000);
    stk_op(1'h1, 24'h341ffe, 1'h0);
    bus_rd(OFS_USP, 32'h1ffe);
    stk_op(1'h0, 24'h341ffe, 1'h0);
    bus_rd(OFS_USP, 32'h2000);
    // Odd pointer: each word goes out as two byte accesses
    bus_wr(OFS_USP, 32'h2001);
    stk_op(1'h1, 24'h341fff, 1'h1);
    stk_op(1'h0, 24'h341fff, 1'h1);
    bus_rd(OFS_USP, 32'h2001);
    irq_try(3'h5, 1'h0, 16'ha040);
    irq_try(3'h3, 1'h1, 16'h6060);
    stk_op(1'h1, 24'h120ffe, 1'h0);
    bus_wr(OFS_STATUS, 32'he000);
    irq_try(3'h1, 1'h0, 16'he000);
    bus_wr(OFS_STATUS, 32'h0040);
    irq_try(3'h0, 1'h0, 16'h0040);
    bus_wr(OFS_STATUS, 32'he040);
    @(posedge mclk);
    swi_req <= 1'h1;
    @(posedge mclk);
    swi_req <= 1'h0;
    @(posedge mclk);
    #1;
    chk("stack select", 32'h1, status_word[SS_BIT]);
    rp_try(8'h07, 5'h07);
    // Reset in mid-run must restore every field that has a reset value
    @(posedge mclk);
    rst_n <= 1'h0;
    repeat (2) @(posedge mclk);
    rst_n <= 1'h1;
    @(posedge mclk);
    #1;
    chk("status after reset", 32'h0020, status_word);
    chk("gpr_base after reset", 32'h000180, gpr_base);
    bus_rd(OFS_RBP, 32'h0);
    end_sim();
  end
endmodule : cpu_status_and_stack_select_tb
